// File: src/tgf_cfg.svh
`ifndef TGF_CFG_SVH
`define TGF_CFG_SVH

// Register offsets
`define TGF_OFS_STATUS     8'h01
`define TGF_OFS_GAIN2      8'h03
`define TGF_OFS_GAIN1      8'h04
`define TGF_OFS_FREQ_HI    8'h0A
`define TGF_OFS_FREQ_MID   8'h0B
`define TGF_OFS_FREQ_LO    8'h0C
`define TGF_OFS_TUNE       8'h0F
`define TGF_OFS_BAND       8'h1A
`define TGF_OFS_CUTOFF     8'h1B
`define TGF_OFS_LOOPCLK    8'h1C
`define TGF_OFS_PASSTHRU   8'h20

// Field positions
`define TGF_BIT_SYNTH_LOCK 6
`define TGF_BIT_CAL_LOCK   5
`define TGF_BIT_GAIN1_HI   7
`define TGF_BIT_ATTEN_HI   3
`define TGF_BIT_ATTEN_LO   2
`define TGF_BIT_TUNE       6
`define TGF_BIT_LOOPCLK    4
`define TGF_BIT_MANUAL     3

// Reset values
`define TGF_RST_GAIN2      8'h00
`define TGF_RST_GAIN1      3'h0
`define TGF_RST_ATTEN      2'h0
`define TGF_RST_BAND       3'h6
`define TGF_RST_CUTOFF     2'h2

// First-stage code forced when the strap holds gain at its floor
`define TGF_GAIN1_FLOOR    3'h0

`endif

// File: src/tgf_pkg.sv
package tgf_pkg;

    // Register write/read request from the serial-bus front end
    typedef struct packed {
        logic       wrStb;
        logic       rdStb;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tgf_req_t;

    // Analog control word presented to the front end
    typedef struct packed {
        logic [7:0] secondGainCode;
        logic [2:0] firstGainCode;
        logic       firstGainAuto;
        logic [1:0] passthruAttenSetting;
        logic       passthruAuto;
        logic [2:0] rfBandSelect;
        logic [1:0] ifLowpassCutoff;
        logic       gainLoopClockEnable;
    } tgf_ctrl_t;

    typedef enum logic [1:0] {
        TGF_IDLE,
        TGF_CALC,
        TGF_WAIT
    } tgf_tune_t;

endpackage

// File: src/tgf_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "tgf_cfg.svh"

// Notes on behaviour
// - Offset 03h holds an 8-bit second-stage gain code, gain is 0.2 dB per step from -12 dB.
// - Offset 04h bit 7 and bits 1:0 hold the first-stage code, 0..3 giving 6, 9, 12, 15 dB.
// - Offset 1Ah bits 2:0 are a write-only band filter select, codes 3 to 6, 6 is bypass.
// - Offset 1Bh bits 1:0 are a write-only cutoff select, codes 0..2 give 6, 7, 8 MHz.
// - Offset 1Ch bit 4 is write-only and turns the clock of both gain loops on or off.
// - Offset 20h bit 3 chooses strap-driven (0) or manual (1) passthrough control.
// - Manual 0 with strap low forces first-stage gain to 6 dB, attenuation from the field.
// - Manual 0 with strap high sets passthrough gain automatically from first-stage gain.
// - Manual 1 with strap low uses the register first-stage code and the attenuation field.
// - Manual 1 with strap high makes first-stage gain automatic, attenuation from the field.
// - Offset 04h bits 3:2 hold the attenuation code, 0..3 giving -6, -9, -12, -15 dB.
// - Offset 01h bit 6 reads synthesizer lock and bit 5 calibration lock, 1 meaning locked.
// - Writing 1 to bit 6 of offset 0Fh while no tune is running starts both synthesizer calculations.
// - The launch bit clears itself once both synthesizer and calibration are done.
// - Offsets 0Ah, 0Bh and 0Ch[7:4] read back frequency bits 31:12 in kHz.
module tgf_regs
    import tgf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire tgf_req_t busReq,
    output logic [7:0] rdData,
    output logic rdValid,
    input wire logic crystal_role_pin,
    input wire logic synthLockIn,
    input wire logic calLockIn,
    input wire logic synthDone,
    input wire logic calDone,
    input wire logic [19:0] synthFreqIn,
    output logic calcStart,
    output tgf_ctrl_t ctrl
);

    logic roleMeta_reg;
    logic roleSync_reg;
    logic [1:0] lockMeta_reg;
    logic [1:0] lockSync_reg;
    logic [7:0] secondGain_reg;
    logic [2:0] firstGain_reg;
    logic [1:0] atten_reg;
    logic [2:0] band_reg;
    logic [1:0] cutoff_reg;
    logic loopClk_reg;
    logic manual_reg;
    logic tuneBusy_reg;
    logic synthDoneSeen_reg;
    logic calDoneSeen_reg;
    logic [19:0] freq_reg;
    logic [7:0] rdData_reg;
    logic rdValid_reg;
    logic calcStart_reg;
    tgf_tune_t tuneState_reg;
    tgf_tune_t tuneState_next;
    logic launchWrite;
    logic [7:0] rdMux;

    // True when a write strobe addresses the given offset
    function automatic logic hit(input tgf_req_t r, input logic [7:0] ofs);
        hit = r.wrStb && (r.addr == ofs);
    endfunction

    // Strap and lock flags come from outside this clock, so two flops each
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            roleMeta_reg <= 1'b0;
            roleSync_reg <= 1'b0;
            lockMeta_reg <= 2'h0;
            lockSync_reg <= 2'h0;
        end else begin
            roleMeta_reg <= crystal_role_pin;
            roleSync_reg <= roleMeta_reg;
            lockMeta_reg <= {synthLockIn, calLockIn};
            lockSync_reg <= lockMeta_reg;
        end
    end

    // Gain and attenuation storage, readable back
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            secondGain_reg <= `TGF_RST_GAIN2;
            firstGain_reg <= `TGF_RST_GAIN1;
            atten_reg <= `TGF_RST_ATTEN;
        end else begin
            if (hit(busReq, `TGF_OFS_GAIN2)) begin
                secondGain_reg <= busReq.wdata;
            end
            if (hit(busReq, `TGF_OFS_GAIN1)) begin
                // Code bit 2 lives in byte bit 7
                firstGain_reg <= {busReq.wdata[`TGF_BIT_GAIN1_HI], busReq.wdata[1:0]};
                atten_reg <= busReq.wdata[`TGF_BIT_ATTEN_HI:`TGF_BIT_ATTEN_LO];
            end
        end
    end

    // Write-only filter, loop and passthrough-mode controls
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            band_reg <= `TGF_RST_BAND;
            cutoff_reg <= `TGF_RST_CUTOFF;
            loopClk_reg <= 1'b0;
            manual_reg <= 1'b0;
        end else begin
            if (hit(busReq, `TGF_OFS_BAND)) begin
                // Reserved codes are stored as written; the analog side decides
                band_reg <= busReq.wdata[2:0];
            end
            if (hit(busReq, `TGF_OFS_CUTOFF)) begin
                cutoff_reg <= busReq.wdata[1:0];
            end
            if (hit(busReq, `TGF_OFS_LOOPCLK)) begin
                loopClk_reg <= busReq.wdata[`TGF_BIT_LOOPCLK];
            end
            if (hit(busReq, `TGF_OFS_PASSTHRU)) begin
                manual_reg <= busReq.wdata[`TGF_BIT_MANUAL];
            end
        end
    end

    assign launchWrite = hit(busReq, `TGF_OFS_TUNE) && busReq.wdata[`TGF_BIT_TUNE];

    // Tune sequencer: launch, then wait for both completions
    always_comb begin
        tuneState_next = tuneState_reg;
        case (tuneState_reg)
            TGF_IDLE: begin
                if (launchWrite) begin
                    tuneState_next = TGF_CALC;
                end
            end
            TGF_CALC: begin
                tuneState_next = TGF_WAIT;
            end
            TGF_WAIT: begin
                if ((synthDoneSeen_reg || synthDone) && (calDoneSeen_reg || calDone)) begin
                    tuneState_next = TGF_IDLE;
                end
            end
            default: begin
                tuneState_next = TGF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tuneState_reg <= TGF_IDLE;
        end else begin
            tuneState_reg <= tuneState_next;
        end
    end

    // Launch pulse and busy bit; the two done events may arrive in any order
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            calcStart_reg <= 1'b0;
            tuneBusy_reg <= 1'b0;
            synthDoneSeen_reg <= 1'b0;
            calDoneSeen_reg <= 1'b0;
        end else begin
            calcStart_reg <= (tuneState_reg == TGF_IDLE) && launchWrite;
            tuneBusy_reg <= (tuneState_next != TGF_IDLE);
            if (tuneState_reg == TGF_CALC || tuneState_next == TGF_IDLE) begin
                synthDoneSeen_reg <= 1'b0;
                calDoneSeen_reg <= 1'b0;
            end else begin
                synthDoneSeen_reg <= synthDoneSeen_reg | synthDone;
                calDoneSeen_reg <= calDoneSeen_reg | calDone;
            end
        end
    end

    // Frequency readback captured when the synthesizer reports done
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            freq_reg <= 20'h00000;
        end else if (synthDone) begin
            freq_reg <= synthFreqIn;
        end
    end

    // Read mux; write-only and unmapped offsets read zero
    always_comb begin
        rdMux = 8'h00;
        case (busReq.addr)
            `TGF_OFS_STATUS: begin
                rdMux[`TGF_BIT_SYNTH_LOCK] = lockSync_reg[1];
                rdMux[`TGF_BIT_CAL_LOCK] = lockSync_reg[0];
            end
            `TGF_OFS_GAIN2: begin
                rdMux = secondGain_reg;
            end
            `TGF_OFS_GAIN1: begin
                rdMux = {firstGain_reg[2], 3'h0, atten_reg, firstGain_reg[1:0]};
            end
            `TGF_OFS_FREQ_HI: begin
                rdMux = freq_reg[19:12];
            end
            `TGF_OFS_FREQ_MID: begin
                rdMux = freq_reg[11:4];
            end
            `TGF_OFS_FREQ_LO: begin
                rdMux = {freq_reg[3:0], 4'h0};
            end
            `TGF_OFS_TUNE: begin
                rdMux[`TGF_BIT_TUNE] = tuneBusy_reg;
            end
            default: begin
                rdMux = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdData_reg <= 8'h00;
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= busReq.rdStb;
            if (busReq.rdStb) begin
                rdData_reg <= rdMux;
            end
        end
    end

    // Gain mode decode from manual bit and strap
    always_comb begin
        ctrl.secondGainCode = secondGain_reg;
        ctrl.passthruAttenSetting = atten_reg;
        ctrl.rfBandSelect = band_reg;
        ctrl.ifLowpassCutoff = cutoff_reg;
        ctrl.gainLoopClockEnable = loopClk_reg;
        ctrl.firstGainCode = firstGain_reg;
        ctrl.firstGainAuto = 1'b0;
        ctrl.passthruAuto = 1'b0;
        case ({manual_reg, roleSync_reg})
            2'b00: begin
                ctrl.firstGainCode = `TGF_GAIN1_FLOOR;
            end
            2'b01: begin
                ctrl.passthruAuto = 1'b1;
            end
            2'b11: begin
                ctrl.firstGainAuto = 1'b1;
            end
            default: begin
                ctrl.firstGainCode = firstGain_reg;
            end
        endcase
    end

    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign calcStart = calcStart_reg;

endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tgf_pkg::*;
    localparam logic [19:0] FRQ = 20'hA5C3E;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    tgf_req_t busReq = '0;
    logic crystal_role_pin = 1'h0;
    logic [7:0] rdData, v;
    logic rdValid, synthLockIn, calLockIn, synthDone, calDone, calcStart;
    logic [19:0] synthFreqIn;
    tgf_ctrl_t ctrl;
    int n_fail = 0;
    int n_compared = 0;
    int i;
    always #20 clk_sys = ~clk_sys;
    tgf_regs DUT (.clk_sys, .rstn, .busReq, .rdData, .rdValid, .crystal_role_pin,
        .synthLockIn, .calLockIn, .synthDone, .calDone, .synthFreqIn, .calcStart, .ctrl);
    tgf_synth_model #(.FREQ(FRQ)) u_synth (.clk_sys, .rstn, .calcStart, .synthDone,
        .calDone, .synthFreqIn, .synthLockIn, .calLockIn);
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Strobes stay up until the next call changes them, so none is driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq.rdStb = 1'h0;
        busReq.wrStb = 1'h1;
        busReq.addr = a;
        busReq.wdata = d;
        @(posedge clk_sys) #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        busReq.wrStb = 1'h0;
        busReq.rdStb = 1'h1;
        busReq.addr = a;
        @(posedge clk_sys) #1;
        chk(rdValid, 1'h1);
        d = rdData;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 rstn = 1'h1;
        chk(ctrl.rfBandSelect, 3'h6);
        chk(ctrl.ifLowpassCutoff, 2'h2);
        rd(8'h01, v);
        chk(v[6:5], 2'h0);
        // Both ends of the second gain range: FFh read straight after write, 00h checked on the control word
        wr(8'h03, 8'hFF);
        rd(8'h03, v);
        chk(v, 8'hFF);
        wr(8'h03, 8'h00);
        chk(ctrl.secondGainCode, 8'h00);
        for (int k = 3; k < 7; k++) begin
            wr(8'h1A, 8'(k) | 8'hF8);
            chk(ctrl.rfBandSelect, 20'(k));
        end
        rd(8'h1A, v);
        chk(v, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(8'h1B, 8'(k));
            chk(ctrl.ifLowpassCutoff, 20'(k));
        end
        wr(8'h1C, 8'h10);
        chk(ctrl.gainLoopClockEnable, 1'h1);
        wr(8'h1C, 8'hEF);
        chk(ctrl.gainLoopClockEnable, 1'h0);
        wr(8'h04, 8'h0F);
        rd(8'h04, v);
        chk(v, 8'h0F);
        // All four strap and manual combinations; strap needs sync time
        for (int m = 0; m < 4; m++) begin
            crystal_role_pin = m[0];
            wr(8'h20, m[1] ? 8'h08 : 8'h00);
            repeat (3) @(posedge clk_sys);
            #1;
            chk(ctrl.passthruAuto, m == 1);
            chk(ctrl.firstGainAuto, m == 3);
            if (m != 3) chk(ctrl.firstGainCode, m == 0 ? 3'h0 : 3'h3);
            chk(ctrl.passthruAttenSetting, 2'h3);
        end
        // Code bit 2 sits in byte bit 7; bits 6 to 4 read back as zero
        wr(8'h04, 8'hF3);
        rd(8'h04, v);
        chk(v, 8'h83);
        chk(ctrl.passthruAttenSetting, 2'h0);
        wr(8'h0F, 8'h40);
        chk(calcStart, 1'h1);
        rd(8'h0F, v);
        chk(v[6], 1'h1);
        wr(8'h0F, 8'h40);
        chk(calcStart, 1'h0);
        for (i = 0; i < 40; i++) begin
            rd(8'h0F, v);
            if (v[6] === 1'h0) break;
        end
        chk(i < 40, 1'h1);
        if (i >= 40) end_of_test();
        repeat (3) @(posedge clk_sys);
        #1;
        rd(8'h01, v);
        chk(v[6:5], 2'h3);
        rd(8'h0A, v);
        chk(v, FRQ[19:12]);
        rd(8'h0B, v);
        chk(v, FRQ[11:4]);
        rd(8'h0C, v);
        chk(v[7:4], FRQ[3:0]);
        end_of_test();
    end
endmodule
`default_nettype wire

// File: tb/tgf_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module tgf_regs_properties
    import tgf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire tgf_req_t busReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic crystal_role_pin,
    input wire logic synthLockIn,
    input wire logic calLockIn,
    input wire logic synthDone,
    input wire logic calDone,
    input wire logic [19:0] synthFreqIn,
    input wire logic calcStart,
    input wire tgf_ctrl_t ctrl
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Write strobe aimed at one offset
    function automatic logic wr_at(input tgf_req_t r, input logic [7:0] a);
        return r.wrStb && (r.addr == a);
    endfunction
    a_gain2_write: assert property (
        wr_at(busReq, 8'h03) |=> ctrl.secondGainCode == $past(busReq.wdata))
        else $error("second gain not stored");
    a_gain2_readback: assert property (
        wr_at(busReq, 8'h03) ##1 (busReq.rdStb && busReq.addr == 8'h03)
        |=> rdData == $past(busReq.wdata, 2)) else $error("second gain readback");
    a_band_write: assert property (
        wr_at(busReq, 8'h1A) |=> ctrl.rfBandSelect == $past(busReq.wdata[2:0]))
        else $error("band select not stored");
    a_cutoff_write: assert property (
        wr_at(busReq, 8'h1B) |=> ctrl.ifLowpassCutoff == $past(busReq.wdata[1:0]))
        else $error("cutoff not stored");
    a_loopclk_write: assert property (
        wr_at(busReq, 8'h1C) |=> ctrl.gainLoopClockEnable == $past(busReq.wdata[4]))
        else $error("loop clock not stored");
    a_atten_write: assert property (
        wr_at(busReq, 8'h04) |=> ctrl.passthruAttenSetting == $past(busReq.wdata[3:2]))
        else $error("attenuation not stored");
    a_read_answer: assert property (
        busReq.rdStb |=> rdValid) else $error("read not answered");
    a_start_cause: assert property (
        calcStart |-> $past(wr_at(busReq, 8'h0F) && busReq.wdata[6]))
        else $error("launch without write");
    a_start_pulse: assert property (
        calcStart |=> !calcStart [*2]) else $error("launch pulse too long");
endmodule
bind tgf_regs tgf_regs_properties u_props (.clk_sys, .rstn, .busReq, .rdData,
    .rdValid, .crystal_role_pin, .synthLockIn, .calLockIn, .synthDone, .calDone,
    .synthFreqIn, .calcStart, .ctrl);
`default_nettype wire

// File: tb/tgf_synth_model.sv
`timescale 1ns/100ps
`default_nettype none
module tgf_synth_model #(
    parameter logic [19:0] FREQ = 20'h12345
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic calcStart,
    output logic synthDone,
    output logic calDone,
    output logic [19:0] synthFreqIn,
    output var logic synthLockIn,
    output var logic calLockIn
);
    logic [3:0] cntReg;
    logic runReg;
    // Slow sequencer so the two done events land well apart
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            runReg <= 1'h0;
            cntReg <= 4'h0;
        end else if (calcStart) begin
            runReg <= 1'h1;
            cntReg <= 4'h0;
        end else if (runReg) begin
            cntReg <= cntReg + 4'h1;
            runReg <= (cntReg != 4'h9);
        end
    end
    assign synthDone = runReg && (cntReg == 4'h5);
    assign calDone = runReg && (cntReg == 4'h9);
    // Inverse off the done cycle so a stale sample cannot pass
    assign synthFreqIn = synthDone ? FREQ : ~FREQ;
    // Locks drop on relaunch, rise with their done event
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            synthLockIn <= 1'h0;
            calLockIn <= 1'h0;
        end else if (calcStart) begin
            synthLockIn <= 1'h0;
            calLockIn <= 1'h0;
        end else begin
            synthLockIn <= synthLockIn | synthDone;
            calLockIn <= calLockIn | calDone;
        end
    end
endmodule
`default_nettype wire
